/* spi_fault_port.sv */
/*
 * serial target port: 32-bit frames, command validity checking,
 * command fault flag and frame error flag.
 * assumes the host drives select, clock and data asynchronously;
 * all three are oversampled by clk through two flip-flops.
 */
`timescale 1ns/1ps

module spi_fault_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial pins
    input wire logic select_n,
    input wire logic sclk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // device state
    input wire spi_fault_pkg::dev_mode_t mode_in,
    input wire logic reset_out_n,
    input wire logic checksum_strap_pin,
    input wire logic checksum_en,
    input wire logic wake_status_set,
    input wire logic wake_sources_set,
    input wire logic wake_sync_pin_is_sync,
    input wire logic [15:0] reply_data,
    input wire logic [7:0] status_field,
    // command results
    output logic cmd_valid,
    output spi_fault_pkg::frame_t cmd_frame,
    output spi_fault_pkg::dev_mode_t mode_req,
    output logic mode_req_valid,
    output logic interrupt_out_n,
    output spi_fault_pkg::fault_t faults,
    output logic frame_done
);

    // ---------------------------------------------------------------
    // pin synchronisers and edges
    // ---------------------------------------------------------------
    logic [1:0] cs_s_q, ck_s_q, di_s_q, rst_s_q;
    logic cs_d1_q, ck_d1_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s_q <= 2'h3;
            ck_s_q <= 2'h0;
            di_s_q <= 2'h0;
            rst_s_q <= 2'h3;
            cs_d1_q <= 1'b1;
            ck_d1_q <= 1'b0;
        end else begin
            cs_s_q <= {cs_s_q[0], select_n};
            ck_s_q <= {ck_s_q[0], sclk};
            di_s_q <= {di_s_q[0], serial_in};
            rst_s_q <= {rst_s_q[0], reset_out_n};
            cs_d1_q <= cs_s_q[1];
            ck_d1_q <= ck_s_q[1];
        end
    end
    logic cs_n, ck, cs_fall, cs_rise, ck_fall, ck_rise, rst_low, port_on;
    assign cs_n = cs_s_q[1];
    assign ck = ck_s_q[1];
    assign rst_low = !rst_s_q[1];
    assign cs_fall = cs_d1_q && !cs_n;
    assign cs_rise = !cs_d1_q && cs_n;
    assign ck_fall = ck_d1_q && !ck && !cs_n;
    assign ck_rise = !ck_d1_q && ck && !cs_n;
    assign port_on = (mode_in == spi_fault_pkg::M_INIT) || (mode_in == spi_fault_pkg::M_NORMAL)
        || (mode_in == spi_fault_pkg::M_STOP);

    // ---------------------------------------------------------------
    // crc-8 over payload bits, msb first
    // ---------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [23:0] p);
        logic [7:0] c;
        c = spi_fault_pkg::CRC_INIT;
        for (int i = spi_fault_pkg::PAYLOAD_BITS - 1; i >= 0; i--) begin
            c = (c[7] ^ p[i]) ? ({c[6:0], 1'b0} ^ spi_fault_pkg::CRC_POLY) : {c[6:0], 1'b0};
        end
        return c ^ spi_fault_pkg::CRC_XOR;
    endfunction

    // ---------------------------------------------------------------
    // frame shifting
    // ---------------------------------------------------------------
    logic [31:0] rx_q, tx_q;
    logic [5:0] cnt_q;
    logic edge_err_q, rst_seen_q, err_pend_q;
    logic [23:0] reply_payload;
    assign reply_payload = {reply_data, status_field};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= '0;
            cnt_q <= '0;
        end else if (cs_fall) begin
            rx_q <= '0;
            cnt_q <= '0;
        end else if (ck_fall) begin
            rx_q <= {rx_q[30:0], di_s_q[1]};
            if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= '0;
        end else if (cs_fall) begin
            // error flag leads the frame before the first rising clock
            tx_q <= {err_pend_q, reply_payload[22:0],
                     checksum_en ? crc8({err_pend_q, reply_payload[22:0]})
                                 : spi_fault_pkg::PAT_OUT};
        end else if (ck_rise) begin
            tx_q <= {tx_q[30:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= !cs_n && port_on && !cs_rise;
            serial_out <= rst_low ? 1'b1 : tx_q[31];
        end
    end

    // ---------------------------------------------------------------
    // frame error tracking
    // ---------------------------------------------------------------
    logic cnt_bad;
    assign cnt_bad = (cnt_q != 6'h00) && (cnt_q != spi_fault_pkg::FRAME_BITS_C);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_err_q <= 1'b0;
            rst_seen_q <= 1'b0;
            err_pend_q <= 1'b0;
        end else begin
            if (cs_fall) begin
                edge_err_q <= ck;
                rst_seen_q <= rst_low;
            end else if (!cs_n && rst_low) begin
                rst_seen_q <= 1'b1;
            end
            if (cs_rise) begin
                err_pend_q <= cnt_bad || ck || edge_err_q || rst_seen_q || rst_low;
            end
        end
    end

    // ---------------------------------------------------------------
    // command check at select rise
    // ---------------------------------------------------------------
    spi_fault_pkg::frame_t f;
    logic [1:0] rq;
    logic frame_ok, addr_used, chk_bad, stuck, is_wr, fault_d, exec_d, init_first;
    logic par_bad, stop_bad, to_stop, first_q;
    spi_fault_pkg::dev_mode_t next_mode;
    always_comb begin
        f = rx_q;
        rq = f.data[spi_fault_pkg::MODE_MSB:spi_fault_pkg::MODE_LSB];
        is_wr = f.wr;
        frame_ok = port_on && !cnt_bad && (cnt_q != 6'h00) && !ck && !edge_err_q
            && !rst_seen_q && !rst_low;
        addr_used = (f.addr >= spi_fault_pkg::ADR_CTRL_LO && f.addr <= spi_fault_pkg::ADR_CTRL_HI)
            || (f.addr >= spi_fault_pkg::ADR_BCTRL_LO && f.addr <= spi_fault_pkg::ADR_BCTRL_HI)
            || (f.addr >= spi_fault_pkg::ADR_STAT_LO && f.addr <= spi_fault_pkg::ADR_STAT_HI)
            || (f.addr >= spi_fault_pkg::ADR_BSTAT_LO && f.addr <= spi_fault_pkg::ADR_BSTAT_HI)
            || (f.addr == spi_fault_pkg::ADR_FAMILY);
        chk_bad = (f.addr != spi_fault_pkg::ADR_DEVSTAT || is_wr) && (checksum_en
            ? (f.chk != crc8(rx_q[23:0])) : (f.chk != spi_fault_pkg::PAT_IN));
        stuck = (rx_q == '0) || (rx_q == '1);
        init_first = first_q && (mode_in == spi_fault_pkg::M_INIT) && checksum_strap_pin;
        par_bad = is_wr && f.addr == spi_fault_pkg::ADR_WDOG && (^f.data);
        to_stop = is_wr && f.addr == spi_fault_pkg::ADR_MODE
            && rq == spi_fault_pkg::REQ_STOP;
        stop_bad = (mode_in == spi_fault_pkg::M_STOP) && is_wr && f.addr != spi_fault_pkg::ADR_WDOG
            && f.addr < spi_fault_pkg::ADR_STAT_LO && f.addr != spi_fault_pkg::ADR_MODE;
        next_mode = mode_in;
        fault_d = 1'b0;
        exec_d = 1'b0;
        if (frame_ok && init_first) begin
            next_mode = spi_fault_pkg::M_NORMAL;
            fault_d = to_stop || (is_wr && f.addr == spi_fault_pkg::ADR_MODE
                && rq == spi_fault_pkg::REQ_SLEEP);
        end else if (frame_ok && stuck) begin
            fault_d = 1'b1;
        end else if (frame_ok && addr_used && !chk_bad) begin
            exec_d = 1'b1;
            if (par_bad || stop_bad) begin
                fault_d = 1'b1;
                exec_d = 1'b0;
            end else if (is_wr && f.addr == spi_fault_pkg::ADR_TIMER
                    && f.data[15:8] >= f.data[7:0]) begin
                fault_d = 1'b1;
                exec_d = 1'b0;
            end else if (is_wr && f.addr == spi_fault_pkg::ADR_HSW
                    && f.data[1:0] == spi_fault_pkg::SYNC_SEL && !wake_sync_pin_is_sync) begin
                fault_d = 1'b1;
                exec_d = 1'b0;
            end else if (is_wr && f.addr == spi_fault_pkg::ADR_MODE) begin
                unique case (rq)
                    spi_fault_pkg::REQ_NORMAL: next_mode = spi_fault_pkg::M_NORMAL;
                    spi_fault_pkg::REQ_STOP: next_mode = spi_fault_pkg::M_STOP;
                    spi_fault_pkg::REQ_SLEEP: next_mode = spi_fault_pkg::M_SLEEP;
                    spi_fault_pkg::REQ_RESET: next_mode = spi_fault_pkg::M_RESTART;
                endcase
                if (mode_in == spi_fault_pkg::M_INIT && (rq == spi_fault_pkg::REQ_STOP
                        || rq == spi_fault_pkg::REQ_SLEEP)) begin
                    fault_d = 1'b1;
                    exec_d = 1'b0;
                    next_mode = spi_fault_pkg::M_NORMAL;
                end else if (mode_in == spi_fault_pkg::M_STOP && rq == spi_fault_pkg::REQ_SLEEP) begin
                    fault_d = 1'b1;
                    exec_d = 1'b0;
                    next_mode = spi_fault_pkg::M_RESTART;
                end else if (rq == spi_fault_pkg::REQ_SLEEP && !wake_sources_set) begin
                    fault_d = 1'b1;
                    next_mode = spi_fault_pkg::M_RESTART;
                end else if (mode_in == spi_fault_pkg::M_STOP && rq == spi_fault_pkg::REQ_STOP) begin
                    exec_d = 1'b0;
                end else if (mode_in == spi_fault_pkg::M_STOP) begin
                    exec_d = 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // results, applied only after select rises
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_frame <= '0;
            mode_req <= spi_fault_pkg::M_INIT;
            mode_req_valid <= 1'b0;
            interrupt_out_n <= 1'b1;
            frame_done <= 1'b0;
            first_q <= 1'b1;
        end else begin
            frame_done <= cs_rise && frame_ok;
            cmd_valid <= cs_rise && exec_d;
            mode_req_valid <= cs_rise && frame_ok && (next_mode != mode_in);
            interrupt_out_n <= !(cs_rise && exec_d && to_stop && wake_status_set);
            if (cs_rise) begin
                cmd_frame <= f;
                mode_req <= next_mode;
            end
            if (mode_in != spi_fault_pkg::M_INIT) first_q <= 1'b1;
            else if (cs_rise && frame_ok) first_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faults <= '0;
        end else begin
            if (cs_rise) faults.err <= cnt_bad || ck || edge_err_q || rst_seen_q || rst_low;
            // set wins over a clear in the same frame
            if (cs_rise && frame_ok && addr_used && !chk_bad && is_wr
                    && f.addr == spi_fault_pkg::ADR_DEVSTAT) begin
                faults.cmd_fault <= fault_d;
                faults.chk_fail <= 1'b0;
            end else begin
                if (cs_rise && fault_d) faults.cmd_fault <= 1'b1;
                if (cs_rise && frame_ok && chk_bad) faults.chk_fail <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_release_out: assert property (@(posedge clk) disable iff (!rst_n)
        cs_rise |=> !serial_out_oe) else $error("output not released");
    a_off_modes: assert property (@(posedge clk) disable iff (!rst_n)
        !port_on |=> !cmd_valid && !serial_out_oe) else $error("port active off");
    a_rst_high: assert property (@(posedge clk) disable iff (!rst_n)
        rst_low |=> serial_out) else $error("output not high in reset");
    a_stuck_fault: assert property (@(posedge clk) disable iff (!rst_n)
        cs_rise && frame_ok && stuck && !init_first
        |=> faults.cmd_fault && !cmd_valid) else $error("stuck frame accepted");
    a_count_err: assert property (@(posedge clk) disable iff (!rst_n)
        cs_rise && cnt_bad |=> faults.err && !cmd_valid) else $error("count error lost");
    a_stop_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        cs_rise && exec_d |-> !(mode_in == spi_fault_pkg::M_STOP
        && next_mode == spi_fault_pkg::M_SLEEP)) else $error("stop to sleep run");
    a_fault_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        faults.cmd_fault && !cs_rise |=> faults.cmd_fault) else $error("fault dropped");
    a_bit_shift: assert property (@(posedge clk) disable iff (!rst_n)
        ck_fall && !cs_fall |=> rx_q[0] == $past(di_s_q[1])) else $error("bit not taken");

endmodule

/* spi_fault_pkg.sv */
/*
 * constants, enums and carriers for the serial target port with
 * command checking and the frame error flag.
 * assumes a 40 MHz system clock that oversamples the serial pins.
 */
package spi_fault_pkg;

    // -------------------------------------------------------------
    // frame layout
    // -------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_BITS_C = 6'h20;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_MSB = 6;
    localparam int WR_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam int DATA_MSB = 23;
    localparam int CHK_LSB = 24;
    localparam int CHK_MSB = 31;
    localparam int PAYLOAD_BITS = 24;

    // -------------------------------------------------------------
    // checksum
    // -------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_XOR = 8'hff;
    localparam logic [7:0] PAT_IN = 8'ha5;
    localparam logic [7:0] PAT_OUT = 8'h5a;

    // -------------------------------------------------------------
    // register addresses seen by the checker
    // -------------------------------------------------------------
    localparam logic [6:0] ADR_MODE = 7'h01;
    localparam logic [6:0] ADR_WDOG = 7'h03;
    localparam logic [6:0] ADR_WAKE = 7'h06;
    localparam logic [6:0] ADR_TIMER = 7'h08;
    localparam logic [6:0] ADR_HSW = 7'h0a;
    localparam logic [6:0] ADR_CTRL_LO = 7'h01;
    localparam logic [6:0] ADR_CTRL_HI = 7'h0b;
    localparam logic [6:0] ADR_BCTRL_LO = 7'h10;
    localparam logic [6:0] ADR_BCTRL_HI = 7'h1d;
    localparam logic [6:0] ADR_STAT_LO = 7'h40;
    localparam logic [6:0] ADR_STAT_HI = 7'h46;
    localparam logic [6:0] ADR_BSTAT_LO = 7'h50;
    localparam logic [6:0] ADR_BSTAT_HI = 7'h5b;
    localparam logic [6:0] ADR_FAMILY = 7'h70;
    localparam logic [6:0] ADR_DEVSTAT = 7'h46;

    // mode field in the mode word, soft reset bit, sync select value
    localparam int MODE_LSB = 14;
    localparam int MODE_MSB = 15;
    localparam int SOFTRST_BIT = 13;
    localparam logic [1:0] SYNC_SEL = 2'h3;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        M_INIT = 3'b000,
        M_NORMAL = 3'b001,
        M_STOP = 3'b010,
        M_SLEEP = 3'b011,
        M_RESTART = 3'b100,
        M_FAILSAFE = 3'b101
    } dev_mode_t;

    typedef enum logic [1:0] {
        REQ_NORMAL = 2'b00,
        REQ_SLEEP = 2'b01,
        REQ_STOP = 2'b10,
        REQ_RESET = 2'b11
    } mode_req_t;

    typedef struct packed {
        logic [7:0] chk;
        logic [15:0] data;
        logic wr;
        logic [6:0] addr;
    } frame_t;

    typedef struct packed {
        logic cmd_fault;
        logic chk_fail;
        logic err;
    } fault_t;

endpackage

/* spi_host_model.sv */
/*
 * host model: drives select, clock and data of frames of n clocks from a 32-bit word, msb first.
 * assumes a free-running clk that paces the 200 ns serial clock.
 */
`timescale 1ns/1ps

module spi_host_model (
    // pacing clock
    input wire logic clk,
    // serial pins
    output logic select_n,
    output logic sclk,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // ----------------------------------------------------------------
    // idle levels
    // ----------------------------------------------------------------
    initial begin
        select_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end

    // ----------------------------------------------------------------
    // one frame of n clocks, hi keeps the clock high at select fall
    // ----------------------------------------------------------------
    task automatic frame(input logic [31:0] w, input int n, input bit hi,
                         output logic [31:0] rx, output logic oe_seen);
        rx = 32'hffffffff;
        if (hi) begin
            sclk <= 1'b1;
            @(posedge clk);
        end
        select_n <= 1'b0;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
        @(negedge clk) begin
            oe_seen = serial_out_oe;
            rx[31] = serial_out;
        end
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge clk);
            @(negedge clk) rx[31 - i] = serial_out;
            @(posedge clk);
            sclk <= 1'b1;
            serial_in <= w[31 - i];
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        select_n <= 1'b1;
        serial_in <= ~serial_in;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* test_spi_fault_port.sv */
/*
 * self-checking bench for the serial target port with a host model.
 * assumes the port answers 3 clk after select rises, per the hand-over.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end

module test_spi_fault_port;
    import spi_fault_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic select_n, sclk, serial_in, serial_out, serial_out_oe;
    dev_mode_t mode_in = M_NORMAL;
    logic reset_out_n = 1'b1;
    logic checksum_strap_pin = 1'b0;
    logic checksum_en = 1'b1;
    logic wake_status_set = 1'b0;
    logic wake_sources_set = 1'b1;
    logic wake_sync_pin_is_sync = 1'b0;
    logic [15:0] reply_data = 16'h0000;
    logic [7:0] status_field = 8'h00;
    logic cmd_valid, mode_req_valid, interrupt_out_n, frame_done;
    frame_t cmd_frame, last_frame;
    dev_mode_t mode_req;
    fault_t faults;
    int failures = 0;
    int check_count = 0;
    int nval, nirq, nfd, nmrv;
    int seed = 32'h9e1b;
    logic [31:0] rx, w;
    logic oe;
    logic [7:0] on_t, per_t;

    always #12.5 clk = ~clk;

    spi_fault_port u_dut (.clk(clk), .rst_n(rst_n), .select_n(select_n), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .mode_in(mode_in), .reset_out_n(reset_out_n), .checksum_strap_pin(checksum_strap_pin),
        .checksum_en(checksum_en), .wake_status_set(wake_status_set),
        .wake_sources_set(wake_sources_set), .wake_sync_pin_is_sync(wake_sync_pin_is_sync),
        .reply_data(reply_data), .status_field(status_field), .cmd_valid(cmd_valid),
        .cmd_frame(cmd_frame), .mode_req(mode_req), .mode_req_valid(mode_req_valid),
        .interrupt_out_n(interrupt_out_n), .faults(faults), .frame_done(frame_done));

    spi_host_model u_host (.clk(clk), .select_n(select_n), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // ----------------------------------------------------------------
    // pulse monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            nval++;
            last_frame = cmd_frame;
        end
        if (interrupt_out_n === 1'b0)
            nirq++;
        if (frame_done === 1'b1)
            nfd++;
        if (mode_req_valid === 1'b1)
            nmrv++;
    end

    // ----------------------------------------------------------------
    // expectations and helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c ^ CRC_XOR;
    endfunction

    function automatic logic [31:0] mk(input logic [6:0] a, input logic [15:0] d);
        return {(checksum_en ? crc8({d, 1'b1, a}) : PAT_IN), d, 1'b1, a};
    endfunction

    task automatic xfer(input logic [31:0] fw, input int n = 32, input bit hi = 0);
        nval = 0;
        nirq = 0;
        nfd = 0;
        nmrv = 0;
        u_host.frame(fw, n, hi, rx, oe);
    endtask

    task automatic clear();
        xfer(mk(ADR_DEVSTAT, 16'h0000));
    endtask

    task automatic fault_case(input logic [31:0] fw, input logic f, input int v);
        xfer(fw);
        `CHK(faults.cmd_fault, f)
        `CHK(nval, v)
        clear();
    endtask

    task automatic mode_case(input dev_mode_t m, input mode_req_t r, input logic src,
                             input logic st, input logic [13:0] rest, input dev_mode_t e,
                             input logic f, input int irq);
        mode_in <= m;
        wake_sources_set <= src;
        wake_status_set <= st;
        @(posedge clk);
        xfer(mk(ADR_MODE, {r, rest}));
        `CHK(mode_req, e)
        `CHK(faults.cmd_fault, f)
        `CHK(nirq, irq)
        `CHK(nmrv, 1)
        clear();
        mode_in <= M_NORMAL;
        wake_sources_set <= 1'b1;
        wake_status_set <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        `CHK({serial_out, serial_out_oe, faults}, 5'h10)
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            checksum_en <= $random(seed);
            reply_data <= $random(seed);
            status_field <= $random(seed);
            per_t = 8'h80 | 8'($random(seed));
            on_t = 8'h7f & 8'($random(seed));
            @(posedge clk);
            w = mk(ADR_TIMER, {on_t, per_t});
            xfer(w);
            `CHK(last_frame, frame_t'(w))
            `CHK(nval, 1)
            `CHK(nfd, 1)
            `CHK(oe, 1'b1)
            `CHK(serial_out_oe, 1'b0)
            `CHK(rx[31:8], {1'b0, reply_data[14:0], status_field})
            `CHK(rx[7:0], checksum_en ? crc8(rx[31:8]) : PAT_OUT)
        end
        $display("test random frames done");
        checksum_en <= 1'b1;
        @(posedge clk);
        fault_case(mk(ADR_TIMER, 16'h2020), 1'b1, 0);
        fault_case(mk(ADR_TIMER, 16'h3020), 1'b1, 0);
        fault_case(mk(ADR_HSW, 16'h0003), 1'b1, 0);
        fault_case(mk(ADR_WDOG, 16'h0001), 1'b1, 0);
        fault_case(mk(ADR_WDOG, 16'h0003), 1'b0, 1);
        fault_case(32'h00000000, 1'b1, 0);
        fault_case(32'hffffffff, 1'b1, 0);
        fault_case(mk(7'h20, 16'h1234), 1'b0, 0);
        wake_sync_pin_is_sync <= 1'b1;
        fault_case(mk(ADR_HSW, 16'h0003), 1'b0, 1);
        xfer(mk(ADR_TIMER, 16'h1020) ^ 32'h01000000);
        `CHK({faults.chk_fail, nval}, {1'b1, 32'd0})
        clear();
        `CHK(faults, 3'h0)
        mode_in <= M_STOP;
        fault_case(mk(ADR_TIMER, 16'h1020), 1'b1, 0);
        $display("test command faults done");
        mode_case(M_STOP, REQ_SLEEP, 1'b1, 1'b0, 14'h0, M_RESTART, 1'b1, 0);
        mode_case(M_INIT, REQ_STOP, 1'b1, 1'b0, 14'h0, M_NORMAL, 1'b1, 0);
        mode_case(M_INIT, REQ_SLEEP, 1'b1, 1'b0, 14'h0, M_NORMAL, 1'b1, 0);
        mode_case(M_NORMAL, REQ_SLEEP, 1'b0, 1'b0, 14'h0, M_RESTART, 1'b1, 0);
        mode_case(M_NORMAL, REQ_STOP, 1'b1, 1'b1, 14'h0, M_STOP, 1'b0, 1);
        mode_case(M_STOP, REQ_NORMAL, 1'b1, 1'b0, 14'h1555, M_NORMAL, 1'b0, 0);
        mode_case(M_NORMAL, REQ_SLEEP, 1'b1, 1'b0, 14'h0, M_SLEEP, 1'b0, 0);
        checksum_strap_pin <= 1'b1;
        mode_case(M_INIT, REQ_STOP, 1'b1, 1'b0, 14'h0, M_NORMAL, 1'b1, 0);
        mode_in <= M_INIT;
        @(posedge clk);
        xfer(mk(ADR_MODE, 16'h0000) ^ 32'h01000000);
        `CHK({mode_req, faults.chk_fail}, {M_NORMAL, 1'b1})
        clear();
        checksum_strap_pin <= 1'b0;
        mode_in <= M_NORMAL;
        $display("test mode requests done");
        xfer(mk(ADR_TIMER, 16'h1020), 31);
        `CHK({nval, faults.err}, {32'd0, 1'b1})
        xfer(32'h0, 0);
        `CHK(rx[31], 1'b1)
        xfer(32'h0, 0);
        `CHK(rx[31], 1'b0)
        xfer(32'h0, 0, 1);
        xfer(32'h0, 0);
        `CHK(rx[31], 1'b1)
        reset_out_n <= 1'b0;
        xfer(mk(ADR_TIMER, 16'h1020));
        `CHK({rx, nval}, {32'hffffffff, 32'd0})
        reset_out_n <= 1'b1;
        xfer(32'h0, 0);
        `CHK(rx[31], 1'b1)
        xfer(32'h0, 0);
        $display("test frame errors done");
        for (int k = 3; k < 6; k++) begin
            mode_in <= dev_mode_t'(3'(k));
            @(posedge clk);
            xfer(mk(ADR_TIMER, 16'h1020));
            `CHK({oe, nval}, {1'b0, 32'd0})
        end
        $display("test inactive modes done");
        wrap_up();
    end

    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        $display("Error at %0t: run timed out", $time);
        wrap_up();
    end
endmodule
